// [hdl/sdcb_pkg.sv]
// Summary of operation
// R1 - all command, address and control inputs are taken on the rising clock edge only
// R2 - controller waits 200us after power-up, then precharges all banks first
// R3 - controller holds byte mask and clock enable high during the power-up pause
// R4 - after all banks precharge, controller issues mode register set
// R5 - controller issues eight auto refreshes before or after mode register set
// R6 - mode register set needs all banks precharged and clock enable high beforehand
// R7 - all four strobes low sets the mode register from the address inputs
// R8 - no command after mode register set until its cycle time has elapsed
// R9 - mode register set cycle time is 16 ns or 20 ns by grade
// R10 - controller activates a bank and waits row-to-column delay before access
// R11 - bank precharged before reactivation, activates spaced by row cycle time
// R12 - activates to different banks spaced by bank-to-bank delay
// R13 - controller precharges each bank before the maximum active time
// R14 - chip select and column strobe low, others high, decodes a burst read
// R15 - chip select, column strobe, write enable low, row strobe high decodes write
// R16 - new row in an open bank needs precharge then activate
// R17 - a read or write is accepted on every clock cycle
// R18 - mode register gives sequential or interleaved bursts of 1, 2, 4, 8 or page
// R19 - write data starts with the command and follows on each next edge
// R20 - data presented after a write burst has finished is ignored
// R21 - a new read drops the old burst and starts a full burst at the new column
// R22 - old read data keeps flowing until the new read's latency has passed
// R23 - controller masks bytes so reads never collide with interrupting writes
// R24 - bank select picks the bank for read, write and single-bank precharge
// R25 - burst stop only during a full-page burst
// R26 - clock enable low during a burst gives clock suspend, not power-down
// R27 - address bit 10 selects auto-precharge on access, all banks on precharge
// R28 - command codes for activate, precharge, refresh, no-op, stop, deselect, self refresh
// R29 - byte mask high disables write data and output drive for that cycle
package sdcb_pkg;
  localparam int unsigned SDCB_BANKS = 4;
  localparam int unsigned SDCB_COL_W = 9;
  localparam int unsigned SDCB_ROW_W = 12;
  localparam int unsigned SDCB_ADDR_W = 12;
  localparam int unsigned SDCB_DATA_W = 8;
  localparam int unsigned SDCB_AP_BIT = 10;
  // mode register field positions
  localparam int unsigned SDCB_MR_BL_LSB = 0;
  localparam int unsigned SDCB_MR_BT_BIT = 3;
  localparam int unsigned SDCB_MR_CL_LSB = 4;
  localparam logic [2:0] SDCB_BL_1 = 3'h0;
  localparam logic [2:0] SDCB_BL_2 = 3'h1;
  localparam logic [2:0] SDCB_BL_4 = 3'h2;
  localparam logic [2:0] SDCB_BL_8 = 3'h3;
  localparam logic [2:0] SDCB_BL_PAGE = 3'h7;
  localparam logic [11:0] SDCB_MR_RESET = 12'h020;
  localparam int unsigned SDCB_CL_MAX = 3;

  // {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] SDCB_CMD_MRS = 4'h0;
  localparam logic [3:0] SDCB_CMD_REF = 4'h1;
  localparam logic [3:0] SDCB_CMD_PRE = 4'h2;
  localparam logic [3:0] SDCB_CMD_ACT = 4'h3;
  localparam logic [3:0] SDCB_CMD_WR = 4'h4;
  localparam logic [3:0] SDCB_CMD_RD = 4'h5;
  localparam logic [3:0] SDCB_CMD_BST = 4'h6;
  localparam logic [3:0] SDCB_CMD_NOP = 4'h7;

  typedef enum {SDCB_PWR_NORMAL, SDCB_PWR_SUSPEND, SDCB_PWR_DOWN, SDCB_PWR_SELF} sdcb_pwr_type;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic dqm;
    logic [1:0] bank_select;
    logic [SDCB_ADDR_W-1:0] addr;
    logic [SDCB_DATA_W-1:0] wdata;
  } sdcb_pins_type;

  typedef struct packed {
    logic wr_en;
    logic [1:0] bank;
    logic [SDCB_ROW_W-1:0] row;
    logic [SDCB_COL_W-1:0] col;
    logic [SDCB_DATA_W-1:0] data;
  } sdcb_wr_type;

  typedef struct packed {
    logic rd_req;
    logic [1:0] bank;
    logic [SDCB_ROW_W-1:0] row;
    logic [SDCB_COL_W-1:0] col;
  } sdcb_rd_type;
endpackage

// [hdl/sdcb_core.sv]
`timescale 1ns/100ps
module sdcb_core #(
  parameter int unsigned CL_MAX = sdcb_pkg::SDCB_CL_MAX
)(
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire sdcb_pkg::sdcb_pins_type pins,
  input wire logic [sdcb_pkg::SDCB_DATA_W-1:0] array_rdata,
  output sdcb_pkg::sdcb_wr_type array_wr,
  output sdcb_pkg::sdcb_rd_type array_rd,
  output logic [sdcb_pkg::SDCB_DATA_W-1:0] dq_o,
  output logic dq_oe,
  output logic [3:0] bank_open,
  output logic [11:0] mode_reg,
  output logic burst_busy,
  output logic [1:0] pwr_state
);
  localparam int unsigned PW = CL_MAX + 2;

  typedef struct packed {
    // read words travel beside their enable bit so data and drive stay aligned
    logic [PW-1:0][sdcb_pkg::SDCB_DATA_W-1:0] rd_data_pipe;
    logic cke_prev;
    logic [11:0] mode;
    logic [3:0] open;
    logic [3:0][sdcb_pkg::SDCB_ROW_W-1:0] row;
    logic active;
    logic is_write;
    logic auto_pre;
    logic [1:0] bank;
    logic [sdcb_pkg::SDCB_COL_W-1:0] start_col;
    logic [sdcb_pkg::SDCB_COL_W-1:0] beat;
    logic [PW-1:0] rd_pipe;
    logic [PW-1:0] mask_pipe;
    logic [1:0] pwr;
    sdcb_pkg::sdcb_wr_type wr;
    sdcb_pkg::sdcb_rd_type rd;
    logic [sdcb_pkg::SDCB_DATA_W-1:0] dq;
    logic dq_oe;
  } sdcb_state_type;

  sdcb_state_type s_q;
  sdcb_state_type s_d;

  logic [3:0] cmd;
  logic cke_now;
  logic [sdcb_pkg::SDCB_COL_W-1:0] blen;
  logic [sdcb_pkg::SDCB_COL_W-1:0] col_now;
  logic [1:0] cl;
  logic page_mode;

  // the latency pipe is sized for two or three cycles only
  if (CL_MAX < 2 || CL_MAX > 3)
  begin : g_cl_check
    $error("CL_MAX must be 2 or 3");
  end

  always_comb
  begin
    // R1 edge-sampled inputs
    cmd = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
    cke_now = pins.cke;
    cl = s_q.mode[sdcb_pkg::SDCB_MR_CL_LSB +: 2];
    // R18 burst length decode
    page_mode = (s_q.mode[sdcb_pkg::SDCB_MR_BL_LSB +: 3] == sdcb_pkg::SDCB_BL_PAGE);
    case (s_q.mode[sdcb_pkg::SDCB_MR_BL_LSB +: 3])
      sdcb_pkg::SDCB_BL_1: blen = 9'h001;
      sdcb_pkg::SDCB_BL_2: blen = 9'h002;
      sdcb_pkg::SDCB_BL_4: blen = 9'h004;
      sdcb_pkg::SDCB_BL_8: blen = 9'h008;
      default: blen = 9'h000;
    endcase
    // R18 sequential or interleaved order
    if (page_mode)
      col_now = s_q.start_col + s_q.beat;
    else if (s_q.mode[sdcb_pkg::SDCB_MR_BT_BIT])
      col_now = s_q.start_col ^ s_q.beat;
    else
      col_now = (s_q.start_col & ~(blen - 9'h001)) | ((s_q.start_col + s_q.beat) & (blen - 9'h001));
  end

  always_comb
  begin
    s_d = s_q;
    s_d.rd_data_pipe = {s_q.rd_data_pipe[PW-2:0], array_rdata};
    s_d.wr.wr_en = 1'b0;
    s_d.rd.rd_req = 1'b0;
    s_d.cke_prev = cke_now;
    s_d.rd_pipe = {s_q.rd_pipe[PW-2:0], 1'b0};
    // R29 mask sampled with each cycle
    s_d.mask_pipe = {s_q.mask_pipe[PW-2:0], pins.dqm};
    // R26 clock enable low: suspend during burst, self refresh with a refresh command, else power-down
    if (!cke_now && s_q.cke_prev)
    begin
      if (s_q.active)
        s_d.pwr = 2'(sdcb_pkg::SDCB_PWR_SUSPEND);
      // R28 self refresh entry
      else if (cmd == sdcb_pkg::SDCB_CMD_REF)
        s_d.pwr = 2'(sdcb_pkg::SDCB_PWR_SELF);
      else
        s_d.pwr = 2'(sdcb_pkg::SDCB_PWR_DOWN);
    end
    else if (cke_now && !s_q.cke_prev)
      s_d.pwr = 2'(sdcb_pkg::SDCB_PWR_NORMAL);
    if (s_q.cke_prev && s_q.pwr == 2'(sdcb_pkg::SDCB_PWR_NORMAL))
    begin
      // burst advance
      if (s_q.active)
      begin
        if (s_q.is_write)
        begin
          s_d.wr.wr_en = !pins.dqm;
          s_d.wr.bank = s_q.bank;
          s_d.wr.row = s_q.row[s_q.bank];
          s_d.wr.col = col_now;
          s_d.wr.data = pins.wdata;
        end
        else
        begin
          s_d.rd.rd_req = 1'b1;
          s_d.rd.bank = s_q.bank;
          s_d.rd.row = s_q.row[s_q.bank];
          s_d.rd.col = col_now;
          s_d.rd_pipe[0] = 1'b1;
        end
        s_d.beat = s_q.beat + 9'h001;
        // R20 burst ends, later data ignored
        if (!page_mode && s_q.beat + 9'h001 >= blen)
        begin
          s_d.active = 1'b0;
          // R27 auto-precharge after burst
          if (s_q.auto_pre)
            s_d.open[s_q.bank] = 1'b0;
        end
      end
      case (cmd)
        // R7 mode register load
        sdcb_pkg::SDCB_CMD_MRS: s_d.mode = pins.addr;
        sdcb_pkg::SDCB_CMD_ACT:
        begin
          s_d.open[pins.bank_select] = 1'b1;
          s_d.row[pins.bank_select] = pins.addr;
        end
        // R24 R27 bank or all-bank precharge
        sdcb_pkg::SDCB_CMD_PRE:
        begin
          if (pins.addr[sdcb_pkg::SDCB_AP_BIT])
            s_d.open = 4'h0;
          else
            s_d.open[pins.bank_select] = 1'b0;
        end
        // R14 R15 R17 R21 new access restarts burst each cycle
        sdcb_pkg::SDCB_CMD_RD, sdcb_pkg::SDCB_CMD_WR:
        begin
          s_d.is_write = !cmd[0];
          s_d.bank = pins.bank_select;
          s_d.auto_pre = pins.addr[sdcb_pkg::SDCB_AP_BIT];
          s_d.start_col = pins.addr[sdcb_pkg::SDCB_COL_W-1:0];
          s_d.beat = 9'h001;
          s_d.active = page_mode || blen > 9'h001;
          if (!cmd[0])
          begin
            // R19 first write word with command
            s_d.wr.wr_en = !pins.dqm;
            s_d.wr.bank = pins.bank_select;
            s_d.wr.row = s_q.row[pins.bank_select];
            s_d.wr.col = pins.addr[sdcb_pkg::SDCB_COL_W-1:0];
            s_d.wr.data = pins.wdata;
          end
          else
          begin
            s_d.rd.rd_req = 1'b1;
            s_d.rd.bank = pins.bank_select;
            s_d.rd.row = s_q.row[pins.bank_select];
            s_d.rd.col = pins.addr[sdcb_pkg::SDCB_COL_W-1:0];
            s_d.rd_pipe[0] = 1'b1;
          end
          // a write takes the data bus, so pending read words are dropped
          if (!cmd[0])
            s_d.rd_pipe = '0;
          if (!s_d.active && s_d.auto_pre)
            s_d.open[pins.bank_select] = 1'b0;
        end
        // R25 stop a full-page burst
        sdcb_pkg::SDCB_CMD_BST: s_d.active = 1'b0;
        default: ;
      endcase
    end
    else if (!s_q.cke_prev && s_q.pwr == 2'(sdcb_pkg::SDCB_PWR_SUSPEND))
    begin
      // suspend holds both output pipes, so a word the array returns in the first suspended cycle is lost
      s_d.rd_pipe = s_q.rd_pipe;
      s_d.rd_data_pipe = s_q.rd_data_pipe;
    end
    // R22 old data drains through latency pipe; R29 mask gates drive
    s_d.dq = s_q.rd_data_pipe[cl - 2'h1];
    s_d.dq_oe = s_q.rd_pipe[cl] && !s_q.mask_pipe[cl - 2'h1] &&
      s_q.pwr != 2'(sdcb_pkg::SDCB_PWR_SELF);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_q <= '0;
      s_q.mode <= sdcb_pkg::SDCB_MR_RESET;
      s_q.cke_prev <= 1'b1;
    end
    else if (clk_en)
      s_q <= s_d;
  end

  assign array_wr = s_q.wr;
  assign array_rd = s_q.rd;
  assign dq_o = s_q.dq;
  assign dq_oe = s_q.dq_oe;
  assign bank_open = s_q.open;
  assign mode_reg = s_q.mode;
  assign burst_busy = s_q.active;
  assign pwr_state = s_q.pwr;
endmodule

// [verification/sdcb_array_model.sv]
`timescale 1ns/100ps
module sdcb_array_model (
  input wire logic clk,
  input wire sdcb_pkg::sdcb_wr_type array_wr,
  input wire sdcb_pkg::sdcb_rd_type array_rd,
  output logic [7:0] array_rdata
);
  logic [7:0] mem [64];
  logic flip = 1'b0;
  initial for (int i = 0; i < 64; i++) mem[i] = 8'hA5 ^ 8'(i);
  always @(posedge clk)
  begin
    flip <= ~flip;
    if (array_wr.wr_en) mem[{array_wr.bank, array_wr.col[3:0]}] <= array_wr.data;
  end
  // idle data toggles so a stale word never passes for an answer
  assign array_rdata = array_rd.rd_req ? mem[{array_rd.bank, array_rd.col[3:0]}] : {8{flip}};
endmodule

// [verification/sdcb_monitor.sv]
`timescale 1ns/100ps
module sdcb_monitor (
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire sdcb_pkg::sdcb_pins_type pins,
  input wire logic [7:0] array_rdata,
  input wire sdcb_pkg::sdcb_wr_type array_wr,
  input wire sdcb_pkg::sdcb_rd_type array_rd,
  input wire logic [7:0] dq_o,
  input wire logic dq_oe,
  input wire logic [3:0] bank_open,
  input wire logic [11:0] mode_reg,
  input wire logic burst_busy,
  input wire logic [1:0] pwr_state
);
  logic cke_q;
  logic go;
  logic [3:0] c;
  assign c = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
  assign go = clk_en && cke_q && pwr_state == 2'h0;
  always_ff @(posedge clk)
  begin
    cke_q <= srst | (clk_en ? pins.cke : cke_q);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  reset_val_a: assert property (disable iff (1'b0) srst && clk_en |=>
    mode_reg == 12'h020 && bank_open == 4'h0) else $error("reset values wrong");
  mode_load_a: assert property (go && c == sdcb_pkg::SDCB_CMD_MRS |=>
    mode_reg == $past(pins.addr)) else $error("mode register not loaded");
  bank_act_a: assert property (go && c == sdcb_pkg::SDCB_CMD_ACT |=>
    bank_open[$past(pins.bank_select)]) else $error("bank not opened");
  pre_all_a: assert property (go && c == sdcb_pkg::SDCB_CMD_PRE && pins.addr[10] |=>
    bank_open == 4'h0) else $error("banks not all closed");
  write_beat_a: assert property (go && c == sdcb_pkg::SDCB_CMD_WR && !pins.dqm |=>
    array_wr.wr_en && array_wr.col == $past(pins.addr[8:0])
    && array_wr.data == $past(pins.wdata)) else $error("first write beat wrong");
  mask_write_a: assert property (go && c == sdcb_pkg::SDCB_CMD_WR && pins.dqm |=>
    !array_wr.wr_en) else $error("masked beat written");
  read_start_a: assert property (go && c == sdcb_pkg::SDCB_CMD_RD |=>
    array_rd.rd_req && array_rd.col == $past(pins.addr[8:0])) else $error("read start wrong");
  read_out_a: assert property (array_rd.rd_req && clk_en |-> ##[1:4] dq_oe)
    else $error("read data never driven");
  freeze_a: assert property (!clk_en |=> $stable(mode_reg) && $stable(bank_open))
    else $error("state moved while frozen");
  suspend_a: assert property (go && burst_busy && !pins.cke |=> ##[0:1] pwr_state == 2'h1)
    else $error("no clock suspend in burst");
  cover property (go && c == sdcb_pkg::SDCB_CMD_RD);
  cover property (array_wr.wr_en);
  cover property (pwr_state == 2'h1);
  cover property (pwr_state == 2'h3);
endmodule

// [verification/testbench.sv]
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  sdcb_pkg::sdcb_pins_type pins = {6'h3F, 22'h0};
  logic [7:0] rdata;
  sdcb_pkg::sdcb_wr_type wr;
  sdcb_pkg::sdcb_rd_type rd;
  logic [7:0] dq_o;
  logic dq_oe;
  logic [3:0] bank_open;
  logic [11:0] mode_reg;
  logic busy;
  logic [1:0] pwr;
  int fail_count = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  sdcb_core i_dut (.clk(clk), .srst(srst), .clk_en(clk_en), .pins(pins), .array_rdata(rdata),
    .array_wr(wr), .array_rd(rd), .dq_o(dq_o), .dq_oe(dq_oe), .bank_open(bank_open),
    .mode_reg(mode_reg), .burst_busy(busy), .pwr_state(pwr));
  sdcb_array_model i_mem (.clk(clk), .array_wr(wr), .array_rd(rd), .array_rdata(rdata));
  task automatic complete_run();
    if (fail_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
    input logic [7:0] d);
    @(posedge clk);
    #1;
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = c;
    pins.bank_select = b;
    pins.addr = a;
    pins.wdata = d;
  endtask
  task automatic idle(input int n);
    repeat (n) issue(sdcb_pkg::SDCB_CMD_NOP, 2'h0, 12'h0, 8'h0);
  endtask
  task automatic t_init();
    check(mode_reg, 12'h020);
    check(bank_open, 4'h0);
    idle(20000);
    issue(sdcb_pkg::SDCB_CMD_PRE, 2'h0, 12'h400, 8'h0);
    pins.dqm = 1'b0;
    // eight refreshes, each after a row cycle gap
    repeat (8)
    begin
      idle(7);
      issue(sdcb_pkg::SDCB_CMD_REF, 2'h0, 12'h0, 8'h0);
    end
    idle(7);
    issue(sdcb_pkg::SDCB_CMD_MRS, 2'h0, 12'h023, 8'h0);
    idle(2);
    check(mode_reg, 12'h023);
  endtask
  task automatic t_banks();
    for (int b = 0; b < 4; b++)
    begin
      issue(sdcb_pkg::SDCB_CMD_ACT, 2'(b), 12'h001, 8'h0);
      idle(2);
    end
    check(bank_open, 4'hF);
    issue(sdcb_pkg::SDCB_CMD_PRE, 2'h2, 12'h000, 8'h0);
    idle(2);
    check(bank_open, 4'hB);
  endtask
  task automatic t_write(input logic [11:0] mode, input logic [8:0] col);
    logic [8:0] exp;
    issue(sdcb_pkg::SDCB_CMD_PRE, 2'h0, 12'h400, 8'h0);
    idle(2);
    check(bank_open, 4'h0);
    issue(sdcb_pkg::SDCB_CMD_MRS, 2'h0, mode, 8'h0);
    idle(2);
    // open then wait row to column
    issue(sdcb_pkg::SDCB_CMD_ACT, 2'h1, 12'h001, 8'h0);
    idle(2);
    issue(sdcb_pkg::SDCB_CMD_WR, 2'h1, {3'h0, col}, 8'h40);
    for (int k = 0; k < 6; k++)
    begin
      issue(sdcb_pkg::SDCB_CMD_NOP, 2'h1, 12'h0, 8'h41 + 8'(k));
      exp = mode[3] ? col ^ 9'(k) : {col[8:2], col[1:0] + 2'(k)};
      check(wr.wr_en, k < 4);
      if (k < 4)
      begin
        check(wr.col, exp);
        check(wr.data, 8'h40 + 8'(k));
      end
    end
  endtask
  task automatic t_read();
    logic [8:0] cols[$];
    logic [7:0] outs[$];
    logic [8:0] ec[5] = '{9'h004, 9'h006, 9'h007, 9'h004, 9'h005};
    logic [7:0] ed[5] = '{8'h41, 8'h43, 8'h42, 8'h41, 8'h40};
    issue(sdcb_pkg::SDCB_CMD_RD, 2'h1, 12'h004, 8'h0);
    for (int k = 0; k < 10; k++)
    begin
      issue(k == 0 ? sdcb_pkg::SDCB_CMD_RD : sdcb_pkg::SDCB_CMD_NOP, 2'h1, 12'h006, 8'h0);
      if (rd.rd_req === 1'b1)
        cols.push_back(rd.col);
      if (dq_oe === 1'b1)
        outs.push_back(dq_o);
    end
    check(cols.size(), 5);
    check(outs.size(), 5);
    for (int i = 0; i < 5; i++)
    begin
      check(cols[i], ec[i]);
      check(outs[i], ed[i]);
    end
  endtask
  task automatic t_suspend();
    issue(sdcb_pkg::SDCB_CMD_WR, 2'h1, 12'h004, 8'h77);
    pins.dqm = 1'b1;
    idle(1);
    pins.dqm = 1'b0;
    pins.cke = 1'b0;
    check(wr.wr_en, 1'b0);
    idle(2);
    check(pwr, 2'h1);
    pins.cke = 1'b1;
    idle(3);
    clk_en = 1'b0;
    issue(sdcb_pkg::SDCB_CMD_ACT, 2'h3, 12'h001, 8'h0);
    idle(1);
    check(bank_open, 4'h2);
    clk_en = 1'b1;
  endtask
  task automatic t_page();
    // banks closed before the page mode is set
    issue(sdcb_pkg::SDCB_CMD_PRE, 2'h0, 12'h400, 8'h0);
    idle(2);
    // page bursts, sequential, then row to column wait
    issue(sdcb_pkg::SDCB_CMD_MRS, 2'h0, 12'h027, 8'h0);
    idle(2);
    issue(sdcb_pkg::SDCB_CMD_ACT, 2'h2, 12'h005, 8'h0);
    idle(2);
    issue(sdcb_pkg::SDCB_CMD_RD, 2'h2, 12'h1FE, 8'h0);
    idle(3);
    check(busy, 1'b1);
    check(rd.col, 9'h000);
    // burst stop inside the page burst only
    issue(sdcb_pkg::SDCB_CMD_BST, 2'h0, 12'h0, 8'h0);
    idle(1);
    check(busy, 1'b0);
    idle(1);
    check(rd.rd_req, 1'b0);
    pins.cke = 1'b0;
    idle(2);
    check(pwr, 2'h2);
    pins.cke = 1'b1;
    idle(2);
    check(pwr, 2'h0);
    issue(sdcb_pkg::SDCB_CMD_PRE, 2'h0, 12'h400, 8'h0);
    idle(2);
    check(bank_open, 4'h0);
    issue(sdcb_pkg::SDCB_CMD_REF, 2'h0, 12'h0, 8'h0);
    pins.cke = 1'b0;
    issue(sdcb_pkg::SDCB_CMD_ACT, 2'h0, 12'h001, 8'h0);
    idle(1);
    check(pwr, 2'h3);
    check(bank_open, 4'h0);
    pins.cke = 1'b1;
    idle(2);
    check(pwr, 2'h0);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    t_init();
    t_banks();
    t_write(12'h022, 9'h006);
    t_write(12'h02A, 9'h005);
    t_read();
    t_suspend();
    t_page();
    complete_run();
  end
  initial
  begin
    #400000;
    fail_count++;
    complete_run();
  end
endmodule
bind sdcb_core sdcb_monitor i_mon (.clk(clk), .srst(srst), .clk_en(clk_en), .pins(pins),
  .array_rdata(array_rdata), .array_wr(array_wr), .array_rd(array_rd), .dq_o(dq_o),
  .dq_oe(dq_oe), .bank_open(bank_open), .mode_reg(mode_reg), .burst_busy(burst_busy),
  .pwr_state(pwr_state));
